// [core/tcpwm_pkg.sv]
// Package with the register map, field layout and reset values of the timer/counter/PWM block
package tcpwm_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int EVT_W = 3;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_COMPARE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;
  localparam logic [7:0] OFS_CAPTURE = 8'h10;
  localparam logic [7:0] OFS_DEADBAND = 8'h14;
  localparam logic [7:0] OFS_PRESCALE = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1C;
  localparam logic [7:0] OFS_MASK = 8'h20;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [15:0] RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] RST_COMPARE = 16'h8000;
  localparam logic [15:0] RST_PRESCALE = 16'h0000;
  localparam logic [7:0] RST_DEADBAND = 8'h00;

  // ----------------------------------------------------------------
  // Event bit positions in status and mask
  // ----------------------------------------------------------------
  localparam int EVT_TC = 0;
  localparam int EVT_CMP = 1;
  localparam int EVT_CAP = 2;
  localparam int STAT_RUN = 3;

  // ----------------------------------------------------------------
  // Modes and control layout
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RUN_FREE = 2'b00, RUN_ONESHOT = 2'b01, RUN_GATED = 2'b10} run_mode_t;
  typedef enum logic [1:0] {CLK_MCLK = 2'b00, CLK_PRESCALE = 2'b01, CLK_EXT = 2'b10} clk_src_t;
  typedef enum logic [2:0] {
    cmp_less = 3'b000,
    cmp_less_or_equal = 3'b001,
    cmp_equal = 3'b010,
    cmp_greater_or_equal = 3'b011,
    cmp_greater = 3'b100
  } cmp_rel_t;

  typedef struct packed {
    logic [22:0] rsvd;
    logic tc_as_cmp_n;
    logic [2:0] cmp_rel;
    logic [1:0] clk_src;
    logic [1:0] run_mode;
    logic start;
  } ctrl_t;

  // Routed inputs after synchronisation
  typedef struct packed {
    logic ext_clk;
    logic kill;
    logic enable;
    logic restart;
    logic capture;
  } route_in_t;

endpackage

// [core/sync2.sv]
// Two-flop synchroniser for signals arriving from the routing fabric
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // Clock, reset, freeze
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule

// [core/deadband_gen.sv]
// Complementary output pair with programmable dead time and kill
`timescale 1ns/1ps
module deadband_gen #(
  parameter int DB_W = 8
) (
  // Clock, reset, freeze
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // Control
  input wire logic raw,
  input wire logic kill,
  input wire logic [DB_W-1:0] dead,
  // Pair
  output logic out_p,
  output logic out_n
);

  logic tgt_r;
  logic [DB_W-1:0] cnt_r;

  // A change of the raw level always leaves at least one cycle with both low
  always_ff @(posedge mclk) begin
    if (reset) begin
      tgt_r <= 1'b0;
      cnt_r <= '0;
      out_p <= 1'b0;
      out_n <= 1'b0;
    end else if (ce) begin
      if (raw != tgt_r) begin
        tgt_r <= raw;
        cnt_r <= dead;
        out_p <= 1'b0; // RULE_10
        out_n <= 1'b0;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else begin
        out_p <= tgt_r & ~kill; // RULE_11
        out_n <= ~tgt_r & ~kill;
      end
      if (kill) begin
        out_p <= 1'b0;
        out_n <= 1'b0;
      end
    end
  end

endmodule

// [core/timer_counter_pwm16.sv]
// Timer/counter/PWM: 16-bit down counter, comparator, capture, deadband pair and APB registers
// Overview of operation
// RULE_01 - The 16-bit counter only ever counts down on the selected clock.
// RULE_02 - Software picks the counting clock: system clock, prescaled clock or external clock.
// RULE_03 - Comparator relation selectable: less, less-equal, equal, greater-equal, greater.
// RULE_04 - Period is loaded on start, on restart input and at terminal count.
// RULE_05 - Terminal count, compare-true and capture each can raise the interrupt.
// RULE_06 - A capture input edge stores the whole 16-bit count for software.
// RULE_07 - Run modes: free running, single shot, or gated by the enable input.
// RULE_08 - Gated mode counts only while enable is held; partner holds it asserted.
// RULE_09 - Single shot stops after one period instead of reloading.
// RULE_10 - Complementary compare pair separated by programmable dead time, never both high.
// RULE_11 - Kill input forces the comparator-driven outputs inactive while asserted.
// RULE_12 - Outputs: compare, terminal count or complementary compare, interrupt request.
// RULE_13 - Restart input reloads the count; capture input latches it.
// RULE_14 - Terminal count pulses one counter clock at zero (code pulses tc_r one mclk cycle on any clock source); count readable while running.
// RULE_15 - Restart, capture, enable and kill are synchronised before use.
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module timer_counter_pwm16 #(
  parameter int DB_W = 8
) (
  // Clock, reset, freeze
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tcpwm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Routed inputs
  input wire logic cap_in,
  input wire logic restart_in,
  input wire logic enable_in,
  input wire logic kill_in,
  input wire logic ext_clk_in,
  // Routed outputs
  output logic cmp_out,
  output logic tc_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  tcpwm_pkg::ctrl_t ctrl_r;
  logic [15:0] period_r;
  logic [15:0] compare_r;
  logic [15:0] prescale_r;
  logic [DB_W-1:0] deadband_r;
  logic [tcpwm_pkg::EVT_W-1:0] status_r;
  logic [tcpwm_pkg::EVT_W-1:0] mask_r;
  logic [tcpwm_pkg::CNT_W-1:0] count_r;
  logic [tcpwm_pkg::CNT_W-1:0] capture_r;
  logic [15:0] presc_cnt_r;
  logic running_r;
  logic start_d_r;
  logic cap_d_r;
  logic ext_d_r;
  logic cmp_d_r;
  logic tc_r;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  tcpwm_pkg::route_in_t rin;

  sync2 #(.W(5)) u_sync (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .d({ext_clk_in, kill_in, enable_in, restart_in, cap_in}), // RULE_15
    .q(rin)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic wr_en;
  logic rd_en;
  logic mapped;

  assign wr_en = psel & penable & pwrite & ~pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;

  always_comb begin
    case (paddr)
      tcpwm_pkg::OFS_CTRL,
      tcpwm_pkg::OFS_PERIOD,
      tcpwm_pkg::OFS_COMPARE,
      tcpwm_pkg::OFS_COUNT,
      tcpwm_pkg::OFS_CAPTURE,
      tcpwm_pkg::OFS_DEADBAND,
      tcpwm_pkg::OFS_PRESCALE,
      tcpwm_pkg::OFS_STATUS,
      tcpwm_pkg::OFS_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Count clock selection and sequencing
  // ----------------------------------------------------------------
  logic tick;
  logic presc_tick;
  logic start_evt;
  logic load_now;
  logic advance;
  logic tc_evt;
  logic cap_evt;
  logic cmp_raw;
  logic cmp_evt;
  logic oneshot;

  // Lowering the prescale below the running count must not cost a full 16-bit wrap
  assign presc_tick = (presc_cnt_r >= prescale_r);
  assign oneshot = (ctrl_r.run_mode == tcpwm_pkg::RUN_ONESHOT);

  always_comb begin
    case (tcpwm_pkg::clk_src_t'(ctrl_r.clk_src))
      tcpwm_pkg::CLK_MCLK: tick = 1'b1; // RULE_02
      tcpwm_pkg::CLK_PRESCALE: tick = presc_tick;
      tcpwm_pkg::CLK_EXT: tick = rin.ext_clk & ~ext_d_r;
      default: tick = 1'b0;
    endcase
  end

  assign start_evt = ctrl_r.start & ~start_d_r;
  assign load_now = start_evt | (rin.restart & ctrl_r.start); // RULE_04 RULE_13
  // Gated mode counts only while the synchronised enable is high
  assign advance = running_r & tick & ~load_now &
                   ((ctrl_r.run_mode != tcpwm_pkg::RUN_GATED) | rin.enable); // RULE_07 RULE_08
  assign tc_evt = advance & (count_r == '0); // RULE_14
  assign cap_evt = rin.capture & ~cap_d_r; // RULE_06
  assign cmp_evt = cmp_raw & ~cmp_d_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      presc_cnt_r <= '0;
    end else if (ce) begin
      presc_cnt_r <= presc_tick ? 16'h0000 : presc_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      start_d_r <= 1'b0;
      cap_d_r <= 1'b0;
      ext_d_r <= 1'b0;
      cmp_d_r <= 1'b0;
    end else if (ce) begin
      start_d_r <= ctrl_r.start;
      cap_d_r <= rin.capture;
      ext_d_r <= rin.ext_clk;
      cmp_d_r <= cmp_raw;
    end
  end

  // Clearing the start bit stops the counter; single shot stops itself at zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      running_r <= 1'b0;
    end else if (ce) begin
      if (!ctrl_r.start) begin
        running_r <= 1'b0;
      end else if (load_now) begin
        running_r <= 1'b1;
      end else if (tc_evt && oneshot) begin
        running_r <= 1'b0; // RULE_09
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      count_r <= tcpwm_pkg::RST_PERIOD;
    end else if (ce) begin
      if (load_now) begin
        count_r <= period_r; // RULE_04
      end else if (advance) begin
        if (count_r == '0) begin
          count_r <= oneshot ? count_r : period_r; // RULE_04 RULE_09
        end else begin
          count_r <= count_r - 1'b1; // RULE_01
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      capture_r <= '0;
      tc_r <= 1'b0;
    end else if (ce) begin
      if (cap_evt) begin
        capture_r <= count_r; // RULE_06
      end
      tc_r <= tc_evt; // RULE_14
    end
  end

  // ----------------------------------------------------------------
  // Comparator and output pair
  // ----------------------------------------------------------------
  always_comb begin
    case (tcpwm_pkg::cmp_rel_t'(ctrl_r.cmp_rel))
      tcpwm_pkg::cmp_less: cmp_raw = count_r < compare_r; // RULE_03
      tcpwm_pkg::cmp_less_or_equal: cmp_raw = count_r <= compare_r;
      tcpwm_pkg::cmp_equal: cmp_raw = count_r == compare_r;
      tcpwm_pkg::cmp_greater_or_equal: cmp_raw = count_r >= compare_r;
      tcpwm_pkg::cmp_greater: cmp_raw = count_r > compare_r;
      default: cmp_raw = 1'b0;
    endcase
  end

  logic db_p;
  logic db_n;

  deadband_gen #(.DB_W(DB_W)) u_db (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .raw(cmp_raw),
    .kill(rin.kill),
    .dead(deadband_r),
    .out_p(db_p),
    .out_n(db_n)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      cmp_out <= 1'b0;
      tc_out <= 1'b0;
    end else if (ce) begin
      cmp_out <= db_p; // RULE_12
      tc_out <= ctrl_r.tc_as_cmp_n ? db_n : tc_r; // RULE_12
    end
  end

  // ----------------------------------------------------------------
  // Software registers, status and interrupt
  // ----------------------------------------------------------------
  logic [tcpwm_pkg::EVT_W-1:0] events;
  logic [tcpwm_pkg::EVT_W-1:0] w1c;

  assign events = {cap_evt, cmp_evt, tc_evt}; // RULE_05
  assign w1c = (wr_en && paddr == tcpwm_pkg::OFS_STATUS) ? pwdata[tcpwm_pkg::EVT_W-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= tcpwm_pkg::RST_CTRL;
      period_r <= tcpwm_pkg::RST_PERIOD;
      compare_r <= tcpwm_pkg::RST_COMPARE;
      prescale_r <= tcpwm_pkg::RST_PRESCALE;
      deadband_r <= DB_W'(tcpwm_pkg::RST_DEADBAND);
      mask_r <= '0;
    end else if (ce && wr_en) begin
      case (paddr)
        tcpwm_pkg::OFS_CTRL: ctrl_r <= {23'h000000, pwdata[8:0]};
        tcpwm_pkg::OFS_PERIOD: period_r <= pwdata[15:0];
        tcpwm_pkg::OFS_COMPARE: compare_r <= pwdata[15:0];
        tcpwm_pkg::OFS_PRESCALE: prescale_r <= pwdata[15:0];
        tcpwm_pkg::OFS_DEADBAND: deadband_r <= pwdata[DB_W-1:0];
        tcpwm_pkg::OFS_MASK: mask_r <= pwdata[tcpwm_pkg::EVT_W-1:0];
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end

  // A new event in the clearing cycle stays set
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_r <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      status_r <= (status_r & ~w1c) | events; // RULE_05
      irq <= |(status_r & mask_r); // RULE_12
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
      prdata <= 32'h0000_0000;
      if (rd_en) begin
        case (paddr)
          tcpwm_pkg::OFS_CTRL: prdata <= ctrl_r;
          tcpwm_pkg::OFS_PERIOD: prdata <= {16'h0000, period_r};
          tcpwm_pkg::OFS_COMPARE: prdata <= {16'h0000, compare_r};
          tcpwm_pkg::OFS_COUNT: prdata <= {16'h0000, count_r}; // RULE_14
          tcpwm_pkg::OFS_CAPTURE: prdata <= {16'h0000, capture_r};
          tcpwm_pkg::OFS_DEADBAND: prdata <= 32'(deadband_r);
          tcpwm_pkg::OFS_PRESCALE: prdata <= {16'h0000, prescale_r};
          tcpwm_pkg::OFS_STATUS: prdata <= {28'h0000000, running_r, status_r};
          tcpwm_pkg::OFS_MASK: prdata <= {29'h00000000, mask_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_count_down: assert property (@(posedge mclk) disable iff (reset) // RULE_01
    ce && advance && count_r != '0 |=> count_r == $past(count_r) - 16'h0001)
    else $error("counter did not step down by one");

  a_tc_reload: assert property (@(posedge mclk) disable iff (reset) // RULE_04
    ce && tc_evt && !oneshot |=> count_r == $past(period_r) && tc_r)
    else $error("terminal count did not reload period");

  a_start_load: assert property (@(posedge mclk) disable iff (reset) // RULE_04
    ce && start_evt |=> count_r == $past(period_r) && running_r)
    else $error("start did not load period");

  a_oneshot_stop: assert property (@(posedge mclk) disable iff (reset) // RULE_09
    ce && tc_evt && oneshot && !load_now |=> !running_r && count_r == 16'h0000)
    else $error("single shot kept running");

  a_gate_hold: assert property (@(posedge mclk) disable iff (reset) // RULE_08
    ce && ctrl_r.run_mode == tcpwm_pkg::RUN_GATED && !rin.enable && !load_now
    |=> count_r == $past(count_r))
    else $error("gated counter moved without enable");

  a_capture_store: assert property (@(posedge mclk) disable iff (reset) // RULE_06
    ce && cap_evt |=> capture_r == $past(count_r) && status_r[tcpwm_pkg::EVT_CAP])
    else $error("capture value or flag wrong");

  a_pair_exclusive: assert property (@(posedge mclk) disable iff (reset) // RULE_10
    ctrl_r.tc_as_cmp_n && $past(ctrl_r.tc_as_cmp_n) |-> !(cmp_out && tc_out))
    else $error("both pair outputs active");

  a_kill_force: assert property (@(posedge mclk) disable iff (reset) // RULE_11
    ce && rin.kill ##1 ce |-> ##1 !cmp_out)
    else $error("kill did not force compare output low");

  a_irq_level: assert property (@(posedge mclk) disable iff (reset) // RULE_05
    ce && (status_r & mask_r) != '0 |=> irq)
    else $error("unmasked event did not raise interrupt");

  a_tc_pulse: assert property (@(posedge mclk) disable iff (reset) // RULE_14
    tc_r && ce |=> !tc_r || $past(tc_evt))
    else $error("terminal count held without a new event");

  c_reload: cover property (@(posedge mclk) disable iff (reset) ce && tc_evt && !oneshot);
  c_oneshot_end: cover property (@(posedge mclk) disable iff (reset) ce && tc_evt && oneshot);
  c_capture: cover property (@(posedge mclk) disable iff (reset) ce && cap_evt);
  c_kill_pair: cover property (@(posedge mclk) disable iff (reset) rin.kill && cmp_raw);

endmodule

// [tb/fabric_model.sv]
// Routing fabric model: drives the routed control inputs and an external count clock
`timescale 1ns/1ps
module fabric_model (
  // Clock
  input wire logic mclk,
  // Routed inputs of the block
  output logic cap_in,
  output logic restart_in,
  output logic enable_in,
  output logic kill_in,
  output logic ext_clk_in
);
  initial begin
    cap_in = 1'b0;
    restart_in = 1'b0;
    enable_in = 1'b0;
    kill_in = 1'b0;
    ext_clk_in = 1'b0;
  end

  // Levels change just after an edge and are held whole cycles, so the synchroniser never misses them
  task automatic lvl(input int which, input logic v);
    @(posedge mclk);
    case (which)
      0: cap_in <= v;
      1: restart_in <= v;
      2: enable_in <= v;
      default: kill_in <= v;
    endcase
  endtask

  // External clock runs only within a burst and rests low between bursts
  task automatic burst(input int n);
    repeat (n) begin
      @(posedge mclk);
      ext_clk_in <= 1'b1;
      repeat (4) @(posedge mclk);
      ext_clk_in <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule

// [tb/tb.sv]
// Self-checking bench for the timer/counter/PWM block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module tb;
  logic mclk, reset, ce, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d, d2, x;
  logic cap_in, restart_in, enable_in, kill_in, ext_clk_in, cmp_out, tc_out, irq;
  logic pulse_mode, pair_mode, tc_prev;
  int err_count, samples_checked, cycles, tc_cnt, both_low, p, seed;
  logic [31:0] rst_v [9] = '{32'h0, 32'hFFFF, 32'h8000, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  timer_counter_pwm16 timer_counter_pwm16_inst (.mclk(mclk), .reset(reset), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .restart_in(restart_in), .enable_in(enable_in), .kill_in(kill_in),
    .ext_clk_in(ext_clk_in), .cmp_out(cmp_out), .tc_out(tc_out), .irq(irq));

  fabric_model fabric_model_inst (.mclk(mclk), .cap_in(cap_in), .restart_in(restart_in),
    .enable_in(enable_in), .kill_in(kill_in), .ext_clk_in(ext_clk_in));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // A hang anywhere ends the run as a failure
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      err_count++;
      conclude();
    end
  end

  // Output monitors sample values settled before each edge
  always @(posedge mclk) begin
    if (pulse_mode) `CHK(tc_out & tc_prev, 1'b0)
    if (pair_mode) `CHK(cmp_out & tc_out, 1'b0)
    if (tc_out === 1'b1) tc_cnt++;
    if (cmp_out === 1'b0 && tc_out === 1'b0) both_low++;
    tc_prev = tc_out;
  end

  // Called just after an edge; request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd_v, output logic er);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never sees pready
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    apb(1'b1, a, v, x, e);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, d, e);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] s, input logic [2:0] r,
    input logic t);
    return {23'h0, t, r, s, m, 1'b1};
  endfunction

  // Reference relation between count and compare value
  function automatic logic rel_f(input int r, input int c, input int k);
    case (r)
      0: return c < k;
      1: return c <= k;
      2: return c == k;
      3: return c >= k;
      default: return c > k;
    endcase
  endfunction

  initial begin
    seed = 32'h977C;
    {reset, ce, psel, penable, pwrite, paddr, pwdata} = {2'b11, 3'b000, 8'h00, 32'h0};
    {err_count, samples_checked, cycles, tc_cnt, both_low} = '0;
    {pulse_mode, pair_mode, tc_prev} = 3'b000;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(8'(i * 4));
      `CHK(d, rst_v[i])
    end
    wr(8'h24, 32'hFFFF_FFFF);
    `CHK(e, 1'b1)
    rd(8'h24);
    `CHK({e, d}, 33'h1_0000_0000)
    // Free run on the system clock with a short period
    wr(tcpwm_pkg::OFS_PERIOD, 32'h3);
    wr(tcpwm_pkg::OFS_MASK, 32'h1);
    pulse_mode = 1'b1;
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 3'h0, 1'h0));
    repeat (8) @(posedge mclk);
    tc_cnt = 0;
    repeat (40) @(posedge mclk);
    `CHK(tc_cnt >= 9 && tc_cnt <= 11, 1'b1)
    `CHK(irq, 1'b1)
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0] <= 16'h3, 1'b1)
    rd(tcpwm_pkg::OFS_STATUS);
    // Loading period 3 makes the count drop below compare, so the compare flag rises as well
    `CHK(d[3:0], 4'hB)
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_STATUS, 32'h7);
    rd(tcpwm_pkg::OFS_STATUS);
    `CHK(d[3:0], 4'h0)
    `CHK(irq, 1'b0)
    // Masked events set status but keep the request low
    wr(tcpwm_pkg::OFS_MASK, 32'h0);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h0, 2'h0, 3'h0, 1'h0));
    repeat (20) @(posedge mclk);
    `CHK(irq, 1'b0)
    rd(tcpwm_pkg::OFS_STATUS);
    `CHK(d[0], 1'b1)
    // Single shot stops at zero with running cleared
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_PERIOD, 32'h5);
    wr(tcpwm_pkg::OFS_STATUS, 32'h7);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h1, 2'h0, 3'h0, 1'h0));
    repeat (20) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0], 16'h0)
    rd(tcpwm_pkg::OFS_STATUS);
    `CHK(d[3:0], 4'h1)
    // Gated mode: capture, enable-held counting, restart
    pulse_mode = 1'b0;
    p = ($random(seed) & 32'hFFF0) | 32'h100;
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_PERIOD, p);
    wr(tcpwm_pkg::OFS_STATUS, 32'h7);
    wr(tcpwm_pkg::OFS_MASK, 32'h4);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h2, 2'h0, 3'h0, 1'h0));
    repeat (4) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0], p[15:0])
    fabric_model_inst.lvl(0, 1'b1);
    repeat (3) @(posedge mclk);
    fabric_model_inst.lvl(0, 1'b0);
    repeat (4) @(posedge mclk);
    rd(tcpwm_pkg::OFS_CAPTURE);
    `CHK(d[15:0], p[15:0])
    `CHK(irq, 1'b1)
    fabric_model_inst.lvl(2, 1'b1);
    repeat (10) @(posedge mclk);
    fabric_model_inst.lvl(2, 1'b0);
    repeat (4) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    d2 = d;
    `CHK(d[15:0] < p[15:0] && d[15:0] >= p[15:0] - 16'h10, 1'b1)
    repeat (5) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d, d2)
    fabric_model_inst.lvl(1, 1'b1);
    repeat (3) @(posedge mclk);
    fabric_model_inst.lvl(1, 1'b0);
    repeat (4) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0], p[15:0])
    // External clock: each rising burst edge is one count
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_PERIOD, 32'h100);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h0, 2'h2, 3'h0, 1'h0));
    repeat (6) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0], 16'h100)
    fabric_model_inst.burst(5);
    repeat (6) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d[15:0], 16'h0FB)
    // Prescaled clock: one tick every four cycles
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_PRESCALE, 32'h3);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h0, 2'h1, 3'h0, 1'h0));
    rd(tcpwm_pkg::OFS_COUNT);
    d2 = d;
    repeat (40) @(posedge mclk);
    rd(tcpwm_pkg::OFS_COUNT);
    `CHK(d2[15:0] - d[15:0] >= 16'hA && d2[15:0] - d[15:0] <= 16'hC, 1'b1)
    // Every relation around the held count, complementary pair on tc_out
    wr(tcpwm_pkg::OFS_CTRL, 32'h0);
    wr(tcpwm_pkg::OFS_PERIOD, p);
    wr(tcpwm_pkg::OFS_STATUS, 32'h7);
    wr(tcpwm_pkg::OFS_CTRL, ctl(2'h2, 2'h0, 3'h0, 1'h1));
    pair_mode = 1'b1;
    for (int r = 0; r < 5; r++) begin
      for (int j = -1; j < 2; j++) begin
        wr(tcpwm_pkg::OFS_COMPARE, p + j);
        wr(tcpwm_pkg::OFS_CTRL, ctl(2'h2, 2'h0, r[2:0], 1'h1));
        repeat (8) @(posedge mclk);
        `CHK(cmp_out, rel_f(r, p, p + j))
        `CHK(tc_out, ~rel_f(r, p, p + j))
      end
    end
    rd(tcpwm_pkg::OFS_STATUS);
    `CHK(d[1], 1'b1)
    // Dead time of five: both low for six cycles on a change
    wr(tcpwm_pkg::OFS_DEADBAND, 32'h5);
    both_low = 0;
    wr(tcpwm_pkg::OFS_COMPARE, p - 1);
    repeat (20) @(posedge mclk);
    `CHK(both_low, 6)
    `CHK({cmp_out, tc_out}, 2'b10)
    fabric_model_inst.lvl(3, 1'b1);
    // Two synchroniser flops, the pair register and the output register lie in the path
    repeat (6) @(posedge mclk);
    `CHK({cmp_out, tc_out}, 2'b00)
    fabric_model_inst.lvl(3, 1'b0);
    repeat (14) @(posedge mclk);
    `CHK({cmp_out, tc_out}, 2'b10)
    conclude();
  end
endmodule
